// file: bench/pdc_comp_model.sv
/*
 * Behavioural stand-in for the analog residual comparators of the six
 * current channels, as seen from the correction bank.
 * Assumes sign-magnitude corrections from the bank and one shared
 * target offset set by the bench.
 */
module pdc_comp_model (
    input wire logic [5:0] sign_in,
    input wire logic [35:0] mag_in,
    input wire logic signed [7:0] target_in,
    output logic [5:0] comp_high_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Residual sign per channel; decoding sign-magnitude back to a value
    // means a wrong conversion steers the search the wrong way
    always_comb
    begin
        int val;
        val = 0;
        for (int i = 0; i < 6; i++)
        begin
            val = int'(mag_in[6*i +: 6]);
            if (sign_in[i])
            begin
                val = -val;
            end
            comp_high_out[i] = (val > int'(target_in));
        end
    end
endmodule

// file: bench/tb.sv
/*
 * Self-checking bench for the pre-driver configuration bank.
 * Assumes the bank is built with a short search length so that search
 * results can be predicted step by step.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int STEPS_TB = 4;
    logic clk_in, rst_in, host_wr_in, host_rd_in, uc_wr_in, comp_busy_out;
    logic [9:0] host_addr_in, uc_addr_in;
    logic [15:0] host_wdata_in, uc_wdata_in, host_rdata_out, rd_val;
    logic [6:0] hs_access_in;
    logic [7:0] ls_access_in, low_side_drain_code_ok_out, low_side_fast_edge_out;
    logic [5:0] comp_start_in, comp_high_in, channel_correction_sign_out;
    logic [47:0] low_side_drain_level_out;
    logic [13:0] high_side_edge_speed_out;
    logic [11:0] low_side_edge_speed_out;
    logic [35:0] channel_correction_magnitude_out;
    logic signed [7:0] target_val;
    int num_errors, comparisons;

    pdc_cfg_regs #(.NUM_CH(6), .STEPS(STEPS_TB)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .host_wr_in(host_wr_in),
        .host_rd_in(host_rd_in), .host_addr_in(host_addr_in),
        .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out),
        .uc_wr_in(uc_wr_in), .uc_addr_in(uc_addr_in), .uc_wdata_in(uc_wdata_in),
        .hs_access_in(hs_access_in), .ls_access_in(ls_access_in),
        .comp_start_in(comp_start_in), .comp_high_in(comp_high_in),
        .comp_busy_out(comp_busy_out),
        .low_side_drain_level_out(low_side_drain_level_out),
        .low_side_drain_code_ok_out(low_side_drain_code_ok_out),
        .high_side_edge_speed_out(high_side_edge_speed_out),
        .low_side_edge_speed_out(low_side_edge_speed_out),
        .low_side_fast_edge_out(low_side_fast_edge_out),
        .channel_correction_sign_out(channel_correction_sign_out),
        .channel_correction_magnitude_out(channel_correction_magnitude_out));

    pdc_comp_model model (.sign_in(channel_correction_sign_out),
        .mag_in(channel_correction_magnitude_out), .target_in(target_val),
        .comp_high_out(comp_high_in));

    // Free-running 100 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Verdict and end of run
    task automatic complete_run();
        if (num_errors == 0 && comparisons > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Single comparison point for all scenarios
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One-cycle host write strobe
    task automatic host_write(input logic [9:0] addr, input logic [15:0] data);
        @(posedge clk_in);
        host_wr_in <= 1'b1;
        host_addr_in <= addr;
        host_wdata_in <= data;
        @(posedge clk_in);
        host_wr_in <= 1'b0;
    endtask

    // Read strobe, data taken one cycle after the read edge
    task automatic host_read(input logic [9:0] addr);
        @(posedge clk_in);
        host_rd_in <= 1'b1;
        host_addr_in <= addr;
        @(posedge clk_in);
        host_rd_in <= 1'b0;
        @(posedge clk_in);
        #1;
        rd_val = host_rdata_out;
    endtask

    // Microcore word write with its access rights
    task automatic uc_write(input logic [9:0] addr, input logic [15:0] data,
        input logic [6:0] hs, input logic [7:0] ls);
        @(posedge clk_in);
        uc_wr_in <= 1'b1;
        uc_addr_in <= addr;
        uc_wdata_in <= data;
        hs_access_in <= hs;
        ls_access_in <= ls;
        @(posedge clk_in);
        uc_wr_in <= 1'b0;
        hs_access_in <= 7'h00;
        ls_access_in <= 8'h00;
    endtask

    // Outputs trail the stored word by one clock
    task automatic settle();
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    // Expected {listed, level in 0.1 V} for a drain code
    function automatic logic [6:0] drain_expect(input int code);
        if (code == 0)
        begin
            return 7'h40;
        end
        if (code >= 9 && code <= 12)
        begin
            return {1'b1, 6'(code - 8)};
        end
        if (code >= 1 && code <= 7)
        begin
            return {1'b1, 6'(code * 5)};
        end
        return 7'h00;
    endfunction

    // All eight registers read zero out of reset
    task automatic check_reset_values();
        check(48'(low_side_drain_code_ok_out), 48'h0000_00ff);
        for (int i = 0; i < 8; i++)
        begin
            host_read(pdc_cfg_pkg::ADDR_LS_THR_LOW + 10'(i));
            check(48'(rd_val), 48'h0000);
        end
    endtask

    // Reserved bits drop writes, unmapped place reads zero
    task automatic check_reserved_bits();
        logic [15:0] masks [8];
        masks = '{16'hffff, 16'hffff, 16'h3fff, 16'h0fff, 16'h00ff,
            16'h3f3f, 16'h3f3f, 16'h3f3f};
        for (int i = 0; i < 8; i++)
        begin
            host_write(pdc_cfg_pkg::ADDR_LS_THR_LOW + 10'(i), 16'hffff);
            host_read(pdc_cfg_pkg::ADDR_LS_THR_LOW + 10'(i));
            check(48'(rd_val), 48'(masks[i]));
            host_write(pdc_cfg_pkg::ADDR_LS_THR_LOW + 10'(i), 16'h0000);
        end
        host_write(10'h177, 16'hffff);
        host_read(10'h177);
        check(48'(rd_val), 48'h0000);
    endtask

    // Every drain code, listed or not, on low-side output 1 and 8
    task automatic check_threshold_decode();
        logic [6:0] e;
        for (int c = 0; c < 16; c++)
        begin
            e = drain_expect(c);
            host_write(pdc_cfg_pkg::ADDR_LS_THR_LOW, 16'(c));
            host_write(pdc_cfg_pkg::ADDR_LS_THR_HIGH, 16'(c) << 12);
            settle();
            check(48'(low_side_drain_level_out[5:0]), 48'(e[5:0]));
            check(48'(low_side_drain_code_ok_out[0]), 48'(e[6]));
            check(48'(low_side_drain_level_out[47:42]), 48'(e[5:0]));
        end
    endtask

    // Edge-rate fields map one-to-one onto outputs
    task automatic check_edge_fields();
        host_write(pdc_cfg_pkg::ADDR_HS_EDGE, 16'h2d1b);
        host_write(pdc_cfg_pkg::ADDR_LS_EDGE_A, 16'hf9c6);
        host_write(pdc_cfg_pkg::ADDR_LS_EDGE_B, 16'hffe4);
        settle();
        check(48'(high_side_edge_speed_out), 48'h2d1b);
        check(48'(low_side_edge_speed_out), 48'h09c6);
        check(48'(low_side_fast_edge_out), 48'h00e4);
    endtask

    // Microcore writes land only where the right is held
    task automatic check_uc_access();
        host_write(pdc_cfg_pkg::ADDR_HS_EDGE, 16'h0000);
        host_write(pdc_cfg_pkg::ADDR_LS_THR_HIGH, 16'h0000);
        uc_write(pdc_cfg_pkg::ADDR_HS_EDGE, 16'h3fff, 7'h01, 8'h00);
        uc_write(pdc_cfg_pkg::ADDR_LS_THR_HIGH, 16'hffff, 7'h00, 8'h80);
        settle();
        check(48'(high_side_edge_speed_out), 48'h0003);
        host_read(pdc_cfg_pkg::ADDR_LS_THR_HIGH);
        check(48'(rd_val), 48'hf000);
        host_write(pdc_cfg_pkg::ADDR_CORR_CH12, 16'h0000);
        uc_write(pdc_cfg_pkg::ADDR_CORR_CH12, 16'h1f1f, 7'h7f, 8'hff);
        host_read(pdc_cfg_pkg::ADDR_CORR_CH12);
        check(48'(rd_val), 48'h0000);
    endtask

    // Host correction reaches the analog side in sign-magnitude
    task automatic check_correction_form();
        host_write(pdc_cfg_pkg::ADDR_CORR_CH12, 16'h3f05);
        host_write(pdc_cfg_pkg::ADDR_CORR_CH56, 16'h2020);
        settle();
        check(48'(channel_correction_sign_out), 48'h0032);
        check(48'(channel_correction_magnitude_out[11:0]), 48'h0045);
        check(48'(channel_correction_magnitude_out[35:24]), 48'h0820);
        host_read(pdc_cfg_pkg::ADDR_CORR_CH12);
        check(48'(rd_val), 48'h3f05);
    endtask

    // Search from a forced start, then into the lower limit
    task automatic run_search(input logic [15:0] start, input logic [15:0] exp);
        logic seen_busy;
        int n;
        seen_busy = 1'b0;
        host_write(pdc_cfg_pkg::ADDR_CORR_CH12, start);
        @(posedge clk_in);
        comp_start_in <= 6'h01; // Channel current held at zero
        @(posedge clk_in);
        comp_start_in <= 6'h00;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk_in);
            #1;
            if (comp_busy_out === 1'b1)
            begin
                seen_busy = 1'b1;
            end
            if (n > 2 && comp_busy_out === 1'b0)
            begin
                break;
            end
        end
        if (n == 200)
        begin
            num_errors++;
            complete_run();
        end
        check(48'(seen_busy), 48'h0001);
        host_read(pdc_cfg_pkg::ADDR_CORR_CH12);
        check(48'(rd_val), 48'(exp));
    endtask

    task automatic check_search();
        target_val = -8'sd40;
        run_search(16'h000a, 16'h0006);
        run_search(16'h0021, 16'h0020);
        settle();
        check(48'(channel_correction_sign_out[0]), 48'h0001);
        check(48'(channel_correction_magnitude_out[5:0]), 48'h0020);
    endtask

    // Main sequence
    initial
    begin
        num_errors = 0;
        comparisons = 0;
        target_val = 8'sh00;
        rst_in = 1'b1;
        host_wr_in = 1'b0;
        host_rd_in = 1'b0;
        host_addr_in = 10'h000;
        host_wdata_in = 16'h0000;
        uc_wr_in = 1'b0;
        uc_addr_in = 10'h000;
        uc_wdata_in = 16'h0000;
        hs_access_in = 7'h00;
        ls_access_in = 8'h00;
        comp_start_in = 6'h00;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        settle();
        check_reset_values();
        check_reserved_bits();
        check_threshold_decode();
        check_edge_fields();
        check_uc_access();
        check_correction_form();
        check_search();
        complete_run();
    end
endmodule

// file: rtl/pdc_cfg_pkg.sv
/*
 * Constants for the pre-driver configuration and current correction bank:
 * register addresses, writable-bit masks, field widths, threshold codes and
 * correction search limits.
 * Assumes a 10-bit register address space and 16-bit register words.
 */
package pdc_cfg_pkg;

    // Register addresses
    localparam logic [9:0] ADDR_LS_THR_LOW = 10'h16f;
    localparam logic [9:0] ADDR_LS_THR_HIGH = 10'h170;
    localparam logic [9:0] ADDR_HS_EDGE = 10'h171;
    localparam logic [9:0] ADDR_LS_EDGE_A = 10'h172;
    localparam logic [9:0] ADDR_LS_EDGE_B = 10'h173;
    localparam logic [9:0] ADDR_CORR_CH12 = 10'h174;
    localparam logic [9:0] ADDR_CORR_CH34 = 10'h175;
    localparam logic [9:0] ADDR_CORR_CH56 = 10'h176;

    // Writable bits; everything else reads zero
    localparam logic [15:0] MASK_LS_THR = 16'hffff;
    localparam logic [15:0] MASK_HS_EDGE = 16'h3fff;
    localparam logic [15:0] MASK_LS_EDGE_A = 16'h0fff;
    localparam logic [15:0] MASK_LS_EDGE_B = 16'h00ff;
    localparam logic [15:0] MASK_CORR = 16'h3f3f;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Field geometry
    localparam int THR_W = 4;
    localparam int EDGE_W = 2;
    localparam int CORR_W = 6;
    localparam int CORR_HI_LSB = 8;
    localparam int LEVEL_W = 6;

    // Threshold codes, level unit is 0.1 V
    localparam logic [3:0] THR_CODE_ZERO = 4'h0;
    localparam logic [3:0] THR_CODE_FINE_LO = 4'h9;
    localparam logic [3:0] THR_CODE_FINE_HI = 4'hc;
    localparam logic [3:0] THR_CODE_COARSE_LO = 4'h1;
    localparam logic [3:0] THR_CODE_COARSE_HI = 4'h7;
    localparam logic [3:0] THR_FINE_BASE = 4'h8;
    localparam logic [5:0] THR_COARSE_STEP = 6'h05;

    // Two's complement correction limits
    localparam logic signed [5:0] CORR_MAX = 6'sh1f;
    localparam logic signed [5:0] CORR_MIN = -6'sh20;

    // Correction search length in comparator decisions
    localparam int SEARCH_STEPS = 64;

    typedef enum logic [2:0] {
        PDC_IDLE = 3'b001,
        PDC_SEARCH = 3'b010,
        PDC_DONE = 3'b100
    } pdc_state_t;

endpackage

// file: rtl/pdc_cfg_regs.sv
/*
 * Configuration bank for the solenoid pre-drivers: low-side drain monitor
 * thresholds, edge-rate selections and per-channel current correction with
 * a runtime search engine.
 * Assumes the serial-port front end delivers one-cycle read and write
 * strobes with address and data, that microcore writes arrive as word
 * writes qualified by per-output access rights, and that the analog side
 * reports the sign of the residual offset on comp_high_in.
 */
module pdc_cfg_regs #(
    parameter int NUM_CH = 6,
    parameter int STEPS = pdc_cfg_pkg::SEARCH_STEPS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [9:0] host_addr_in,
    input wire logic [15:0] host_wdata_in,
    output logic [15:0] host_rdata_out,
    input wire logic uc_wr_in,
    input wire logic [9:0] uc_addr_in,
    input wire logic [15:0] uc_wdata_in,
    input wire logic [6:0] hs_access_in,
    input wire logic [7:0] ls_access_in,
    input wire logic [NUM_CH-1:0] comp_start_in,
    input wire logic [NUM_CH-1:0] comp_high_in,
    output logic comp_busy_out,
    output logic [47:0] low_side_drain_level_out,
    output logic [7:0] low_side_drain_code_ok_out,
    output logic [13:0] high_side_edge_speed_out,
    output logic [11:0] low_side_edge_speed_out,
    output logic [7:0] low_side_fast_edge_out,
    output logic [NUM_CH-1:0] channel_correction_sign_out,
    output logic [NUM_CH*6-1:0] channel_correction_magnitude_out
);

    logic [15:0] thr_low_r;   // Drain codes, outputs 1..4
    logic [15:0] thr_high_r;  // Drain codes, outputs 5..8
    logic [15:0] hs_edge_r;   // High-side edge rates
    logic [15:0] ls_edge_a_r; // Low-side 1..6 edge rates
    logic [15:0] ls_edge_b_r; // Low-side 7, 8 rise and fall
    logic signed [5:0] corr_r [NUM_CH]; // Stored corrections
    pdc_cfg_pkg::pdc_state_t state_r;
    logic [2:0] ch_sel_r;     // Channel under search
    logic [7:0] step_cnt_r;   // Decisions left
    logic [15:0] thr_low_ok, thr_high_ok, hs_ok, ls_a_ok, ls_b_ok;
    logic [NUM_CH-1:0] start_pend_r; // Latched start requests
    logic [2:0] next_ch;

    // Nibble-wide access mask from four access bits
    function automatic logic [15:0] nib_mask(input logic [3:0] acc);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*4 +: 4] = {4{acc[i]}};
        end
        return m;
    endfunction

    // Two-bit-wide access mask from up to eight access bits
    function automatic logic [15:0] pair_mask(input logic [7:0] acc);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < 8; i++)
        begin
            m[i*2 +: 2] = {2{acc[i]}};
        end
        return m;
    endfunction

    // Drain code to level in 0.1 V units; unlisted codes flag not ok
    function automatic logic [6:0] thr_decode(input logic [3:0] code);
        logic [6:0] res;
        res = {1'b0, 6'h00};
        if (code == pdc_cfg_pkg::THR_CODE_ZERO)
        begin
            res = {1'b1, 6'h00};
        end
        else if (code >= pdc_cfg_pkg::THR_CODE_FINE_LO && code <= pdc_cfg_pkg::THR_CODE_FINE_HI)
        begin
            res = {1'b1, 2'b00, code - pdc_cfg_pkg::THR_FINE_BASE};
        end
        else if (code >= pdc_cfg_pkg::THR_CODE_COARSE_LO &&
                 code <= pdc_cfg_pkg::THR_CODE_COARSE_HI)
        begin
            res = {1'b1, 6'((6'(code) * pdc_cfg_pkg::THR_COARSE_STEP))};
        end
        return res;
    endfunction

    // Access-gated masks; a field with no right keeps its value
    always_comb
    begin
        thr_low_ok = nib_mask(ls_access_in[3:0]);
        thr_high_ok = nib_mask(ls_access_in[7:4]);
        hs_ok = pair_mask({1'b0, hs_access_in}) & pdc_cfg_pkg::MASK_HS_EDGE;
        ls_a_ok = pair_mask({2'b00, ls_access_in[5:0]}) & pdc_cfg_pkg::MASK_LS_EDGE_A;
        // Low-side 7 owns the low nibble, 8 the next
        ls_b_ok = {8'h00, {4{ls_access_in[7]}}, {4{ls_access_in[6]}}};
    end

    // Threshold and edge-rate words; host write wins over a microcore write
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            thr_low_r <= pdc_cfg_pkg::RESET_WORD;
            thr_high_r <= pdc_cfg_pkg::RESET_WORD;
            hs_edge_r <= pdc_cfg_pkg::RESET_WORD;
            ls_edge_a_r <= pdc_cfg_pkg::RESET_WORD;
            ls_edge_b_r <= pdc_cfg_pkg::RESET_WORD;
        end
        else if (host_wr_in)
        begin
            // Reserved bits masked off here so they never store
            case (host_addr_in)
                pdc_cfg_pkg::ADDR_LS_THR_LOW: thr_low_r <= host_wdata_in;
                pdc_cfg_pkg::ADDR_LS_THR_HIGH: thr_high_r <= host_wdata_in;
                pdc_cfg_pkg::ADDR_HS_EDGE:
                    hs_edge_r <= host_wdata_in & pdc_cfg_pkg::MASK_HS_EDGE;
                pdc_cfg_pkg::ADDR_LS_EDGE_A:
                    ls_edge_a_r <= host_wdata_in & pdc_cfg_pkg::MASK_LS_EDGE_A;
                pdc_cfg_pkg::ADDR_LS_EDGE_B:
                    ls_edge_b_r <= host_wdata_in & pdc_cfg_pkg::MASK_LS_EDGE_B;
                default: ;
            endcase
        end
        else if (uc_wr_in)
        begin
            // Merge only the bits the microcore may touch
            case (uc_addr_in)
                pdc_cfg_pkg::ADDR_LS_THR_LOW:
                    thr_low_r <= (thr_low_r & ~thr_low_ok) | (uc_wdata_in & thr_low_ok);
                pdc_cfg_pkg::ADDR_LS_THR_HIGH:
                    thr_high_r <= (thr_high_r & ~thr_high_ok) | (uc_wdata_in & thr_high_ok);
                pdc_cfg_pkg::ADDR_HS_EDGE:
                    hs_edge_r <= (hs_edge_r & ~hs_ok) | (uc_wdata_in & hs_ok);
                pdc_cfg_pkg::ADDR_LS_EDGE_A:
                    ls_edge_a_r <= (ls_edge_a_r & ~ls_a_ok) | (uc_wdata_in & ls_a_ok);
                pdc_cfg_pkg::ADDR_LS_EDGE_B:
                    ls_edge_b_r <= (ls_edge_b_r & ~ls_b_ok) | (uc_wdata_in & ls_b_ok);
                default: ;
            endcase
        end
    end

    // Lowest pending channel goes next
    always_comb
    begin
        next_ch = 3'd0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (start_pend_r[i])
            begin
                next_ch = 3'(i);
            end
        end
    end

    // Search sequencer; one channel at a time keeps a single engine
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_r <= pdc_cfg_pkg::PDC_IDLE;
            ch_sel_r <= 3'd0;
            step_cnt_r <= 8'h00;
            start_pend_r <= '0;
        end
        else
        begin
            // New requests are never lost, even while the engine is busy
            start_pend_r <= start_pend_r | comp_start_in;
            case (state_r)
                pdc_cfg_pkg::PDC_IDLE:
                begin
                    if (|start_pend_r)
                    begin
                        ch_sel_r <= next_ch;
                        step_cnt_r <= 8'(STEPS);
                        start_pend_r[next_ch] <= comp_start_in[next_ch];
                        state_r <= pdc_cfg_pkg::PDC_SEARCH;
                    end
                end
                pdc_cfg_pkg::PDC_SEARCH:
                begin
                    step_cnt_r <= step_cnt_r - 8'd1;
                    if (step_cnt_r == 8'd1)
                    begin
                        state_r <= pdc_cfg_pkg::PDC_DONE;
                    end
                end
                pdc_cfg_pkg::PDC_DONE: state_r <= pdc_cfg_pkg::PDC_IDLE;
                default: state_r <= pdc_cfg_pkg::PDC_IDLE;
            endcase
        end
    end

    // Correction values: host write replaces, search steps by one LSB
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                corr_r[i] <= '0;
            end
        end
        else
        begin
            if (state_r == pdc_cfg_pkg::PDC_SEARCH)
            begin
                // Walks on from whatever is stored now, forced or found
                if (comp_high_in[ch_sel_r] && corr_r[ch_sel_r] != pdc_cfg_pkg::CORR_MIN)
                begin
                    corr_r[ch_sel_r] <= corr_r[ch_sel_r] - 6'sd1;
                end
                else if (!comp_high_in[ch_sel_r] && corr_r[ch_sel_r] != pdc_cfg_pkg::CORR_MAX)
                begin
                    corr_r[ch_sel_r] <= corr_r[ch_sel_r] + 6'sd1;
                end
            end
            // Host write comes last so it always takes effect
            for (int p = 0; p < NUM_CH / 2; p++)
            begin
                if (host_wr_in && host_addr_in == pdc_cfg_pkg::ADDR_CORR_CH12 + 10'(p))
                begin
                    corr_r[2*p] <= host_wdata_in[pdc_cfg_pkg::CORR_W-1:0];
                    corr_r[2*p+1] <= host_wdata_in[pdc_cfg_pkg::CORR_HI_LSB +:
                                                   pdc_cfg_pkg::CORR_W];
                end
            end
        end
    end

    // Registered decoded outputs for the analog section
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            low_side_drain_level_out <= '0;
            low_side_drain_code_ok_out <= '0;
            channel_correction_sign_out <= '0;
            channel_correction_magnitude_out <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                {low_side_drain_code_ok_out[i], low_side_drain_level_out[i*6 +: 6]} <=
                    thr_decode(thr_low_r[i*4 +: 4]);
                {low_side_drain_code_ok_out[i+4], low_side_drain_level_out[(i+4)*6 +: 6]} <=
                    thr_decode(thr_high_r[i*4 +: 4]);
            end
            for (int i = 0; i < NUM_CH; i++)
            begin
                // Sign-magnitude; -32 gives magnitude 32, hence 6 bits
                channel_correction_sign_out[i] <= corr_r[i][5];
                channel_correction_magnitude_out[i*6 +: 6] <=
                    corr_r[i][5] ? 6'(-corr_r[i]) : 6'(corr_r[i]);
            end
        end
    end

    // Edge-rate outputs mirror the stored fields; low-side 7, 8 keep separate rise and fall
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            high_side_edge_speed_out <= '0;
            low_side_edge_speed_out <= '0;
            low_side_fast_edge_out <= '0;
            comp_busy_out <= 1'b0;
        end
        else
        begin
            high_side_edge_speed_out <= hs_edge_r[13:0];
            low_side_edge_speed_out <= ls_edge_a_r[11:0];
            low_side_fast_edge_out <= ls_edge_b_r[7:0];
            comp_busy_out <= (state_r != pdc_cfg_pkg::PDC_IDLE) || (|start_pend_r);
        end
    end

    // Read port, one cycle after the strobe; reserved bits are zero
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            host_rdata_out <= pdc_cfg_pkg::RESET_WORD;
        end
        else if (host_rd_in)
        begin
            case (host_addr_in)
                pdc_cfg_pkg::ADDR_LS_THR_LOW: host_rdata_out <= thr_low_r;
                pdc_cfg_pkg::ADDR_LS_THR_HIGH: host_rdata_out <= thr_high_r;
                pdc_cfg_pkg::ADDR_HS_EDGE: host_rdata_out <= hs_edge_r;
                pdc_cfg_pkg::ADDR_LS_EDGE_A: host_rdata_out <= ls_edge_a_r;
                pdc_cfg_pkg::ADDR_LS_EDGE_B: host_rdata_out <= ls_edge_b_r;
                pdc_cfg_pkg::ADDR_CORR_CH12:
                    host_rdata_out <= {2'b00, corr_r[1], 2'b00, corr_r[0]};
                pdc_cfg_pkg::ADDR_CORR_CH34:
                    host_rdata_out <= {2'b00, corr_r[3], 2'b00, corr_r[2]};
                pdc_cfg_pkg::ADDR_CORR_CH56:
                    host_rdata_out <= {2'b00, corr_r[5], 2'b00, corr_r[4]};
                default: host_rdata_out <= pdc_cfg_pkg::RESET_WORD;
            endcase
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_host_corr_wr;
        host_wr_in && host_addr_in == pdc_cfg_pkg::ADDR_CORR_CH12;
    endsequence

    chk_uc_no_right: assert property (uc_wr_in && !host_wr_in && ls_access_in[4] == 1'b0 &&
        uc_addr_in == pdc_cfg_pkg::ADDR_LS_THR_HIGH |=> $stable(thr_high_r[3:0]))
        else $error("microcore write without right changed a threshold");
    chk_host_thr_wr: assert property (host_wr_in &&
        host_addr_in == pdc_cfg_pkg::ADDR_LS_THR_HIGH |=> thr_high_r == $past(host_wdata_in))
        else $error("host threshold write not stored");
    chk_thr_decode: assert property (thr_low_r[3:0] == 4'h3 ##1 thr_low_r[3:0] == 4'h3
        |-> low_side_drain_level_out[5:0] == 6'd15 && low_side_drain_code_ok_out[0])
        else $error("threshold decode wrong");
    chk_reserved_zero: assert property (host_rd_in &&
        host_addr_in == pdc_cfg_pkg::ADDR_HS_EDGE |=> host_rdata_out[15:14] == 2'b00)
        else $error("reserved bits not zero");
    chk_corr_replace: assert property (s_host_corr_wr |=>
        corr_r[0] == $past(host_wdata_in[5:0]) && corr_r[1] == $past(host_wdata_in[13:8]))
        else $error("host correction write lost");
    // Saturation at the lower limit keeps the value inside -32..31
    chk_corr_range: assert property (state_r == pdc_cfg_pkg::PDC_SEARCH &&
        ch_sel_r == 3'h0 && corr_r[0] == pdc_cfg_pkg::CORR_MIN && comp_high_in[0] &&
        !host_wr_in |=> corr_r[0] == pdc_cfg_pkg::CORR_MIN)
        else $error("correction left its lower limit");
    chk_search_step: assert property (state_r == pdc_cfg_pkg::PDC_SEARCH &&
        ch_sel_r == 3'h0 && comp_high_in[0] && corr_r[0] != pdc_cfg_pkg::CORR_MIN &&
        !host_wr_in |=> corr_r[0] == $past(corr_r[0]) - 6'sh01)
        else $error("search did not step from stored value");
    chk_sign_mag: assert property (corr_r[1] == -6'sh01 ##1 corr_r[1] == -6'sh01
        |-> channel_correction_sign_out[1] && channel_correction_magnitude_out[11:6] == 6'h01)
        else $error("sign-magnitude conversion wrong");
    chk_read_corr: assert property (host_rd_in && !host_wr_in &&
        host_addr_in == pdc_cfg_pkg::ADDR_CORR_CH56 |=> host_rdata_out[5:0] == $past(corr_r[4]))
        else $error("correction readback wrong");
    chk_fast_edge: assert property ($changed(ls_edge_b_r) |=>
        low_side_fast_edge_out == $past(ls_edge_b_r[7:0]))
        else $error("fast edge output not following register");

endmodule
